// ===== core/omd_pkg.sv
// Shared constants, types and helper functions of the on-card memory decoder.
package omd_pkg;
	// Board clock rate and the slowest ROM access that the socket timing must cover.
	localparam int CLK_MHZ = 100;
	localparam int ROM_ACC_NS = 250;
	localparam logic [4:0] ROM_WAIT = 5'((ROM_ACC_NS * CLK_MHZ + 999) / 1000);

	// Address decode fields.
	localparam int ROM_BITS = 22;
	localparam logic [8:0] ROM_TOP = 9'h000;
	localparam logic [7:0] DRAM_TOP = 8'h03;
	localparam logic [23:0] NV_WIN_TOP = 24'h025000;
	localparam logic [31:0] NV_STORE = 32'h0260_0000;
	localparam logic [31:0] NV_RECALL = 32'h0270_0000;
	localparam int NV_WORDS = 256;

	// Wait states per DRAM speed grade and for later burst beats.
	localparam logic [4:0] RD_W_100 = 5'h3;
	localparam logic [4:0] WR_W_100 = 5'h3;
	localparam logic [4:0] RD_W_80 = 5'h3;
	localparam logic [4:0] WR_W_80 = 5'h2;
	localparam logic [4:0] RD_W_60 = 5'h2;
	localparam logic [4:0] WR_W_60 = 5'h2;
	localparam logic [4:0] BURST_W = 5'h1;
	localparam logic [1:0] LAST_BEAT = 2'h3;

	typedef enum logic [1:0] {
		OMD_SPD_100,
		OMD_SPD_80,
		OMD_SPD_60
	} omd_speed_t;

	// Odd parity, one bit for each byte lane.
	function automatic logic [3:0] omd_lane_par(input logic [31:0] d);
		logic [3:0] p;
		for (int i = 0; i < 4; i++) begin
			p[i] = ~^d[8*i +: 8];
		end
		return p;
	endfunction : omd_lane_par

	// Wait states of the first beat for a speed grade and direction.
	function automatic logic [4:0] omd_first_wait(input omd_speed_t spd, input logic wr);
		logic [4:0] w;
		unique case (spd)
			OMD_SPD_80: w = wr ? WR_W_80 : RD_W_80;
			OMD_SPD_60: w = wr ? WR_W_60 : RD_W_60;
			default: w = wr ? WR_W_100 : RD_W_100;
		endcase
		return w;
	endfunction : omd_first_wait
endpackage : omd_pkg

// ===== core/omd_nv_if.sv
// Link between the decoder and the nonvolatile nibble memory.
`timescale 1ns/1ps
interface omd_nv_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [3:0] wdata;
	logic [3:0] rdata;
	logic store;
	logic recall;

	modport ctl(output req, output we, output addr, output wdata, output store, output recall, input rdata);
	modport mem(input req, input we, input addr, input wdata, input store, input recall, output rdata);
endinterface : omd_nv_if

// ===== core/omd_nvram.sv
// Shadow nibble RAM with its nonvolatile twin and the store/recall copy engine.
`timescale 1ns/1ps
module omd_nvram (
	input wire logic clk, // Board clock.
	input wire logic rst_n, // Synchronous reset, active low.
	omd_nv_if.mem nv // Port from the decoder.
);
	import omd_pkg::*;

	typedef struct packed {
		logic busy;
		logic dir_store;
		logic [7:0] idx;
		logic [3:0] rdata;
	} omd_nvs_t;

	omd_nvs_t r;
	omd_nvs_t next_r;
	logic [3:0] shadow [NV_WORDS];
	logic [3:0] cells [NV_WORDS];

	// Copy engine walks all words once per store or recall; the bus is never held off.
	always_comb begin
		next_r = r;
		if (nv.req) begin
			next_r.rdata = shadow[nv.addr];
		end
		if (r.busy) begin
			next_r.idx = r.idx + 8'h01;
			next_r.busy = (r.idx != 8'hff);
		end
		if (nv.store || nv.recall) begin
			next_r.busy = 1'b1;
			next_r.dir_store = nv.store;
			next_r.idx = 8'h00;
		end
	end

	// State register; the arrays keep no reset, so contents start undefined.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Array writes: copy step first, a direct processor write wins on the same word.
	always_ff @(posedge clk) begin
		if (r.busy && r.dir_store) begin
			cells[r.idx] <= shadow[r.idx];
		end
		if (r.busy && !r.dir_store) begin
			shadow[r.idx] <= cells[r.idx];
		end
		if (nv.req && nv.we) begin
			shadow[nv.addr] <= nv.wdata;
		end
	end

	assign nv.rdata = r.rdata;

	// A direct write followed by a read of the same word returns the written nibble.
	nv_direct_rw_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
		nv.req && nv.we && !r.busy ##3 nv.req && !nv.we && nv.addr == $past(nv.addr, 3) && !r.busy
		|=> nv.rdata == $past(nv.wdata, 4))
		else $error("direct nibble access lost data");
endmodule : omd_nvram

// ===== core/omd_decode.sv
// On-card memory decoder: boot ROM sockets, parity DRAM and nonvolatile RAM.
// How it works
// RULE1: Lower ROM repeats across its region, so a mirror sits below the upper ROM.
// RULE2: Each socket serves every byte address itself as an 8-bit port.
// RULE3: Writes to a socket region pass through, allowing paged ROM page select.
// RULE4: Writes to a socket reach a fitted EEPROM to alter single locations.
// RULE5: Software paces EEPROM writes itself; hardware adds no delay.
// RULE6: The EEPROM ready line is passed on to the parallel I/O input.
// RULE7: DRAM holds 32 data bits and four parity bits, one per byte.
// RULE8: DRAM is decoded from 0300,0000 over a 16 megabyte region.
// RULE9: Reads above installed DRAM end normally; bad parity may flag an error.
// RULE10: Software sizes DRAM by byte-writing a pattern and reading it back.
// RULE11: First-beat wait states follow the DRAM speed grade; later beats wait one.
// RULE12: The processor needs at least two clocks per access, one per burst beat.
// RULE13: Nonvolatile RAM is 256 nibbles on the low half of the byte.
// RULE14: The 256-byte window at 0250,00xx reaches the shadow nibbles directly.
// RULE15: A read of 0270,0000 starts a recall into the shadow RAM.
// RULE16: A write to 0260,0000 starts a store into the nonvolatile array.
// RULE17: Software starts a store only with a test-and-set cycle.
// RULE18: Store and recall never stall the bus; the trigger cycle ends normally.
// RULE19: Software waits after store or recall before the next nibble access.
// RULE20: Software recalls once after power-up before using the nibble RAM.
// RULE21: Each socket owns a fixed 4 megabyte region, the lower one from zero.
// RULE22: A DRAM read parity error raises the level 7 request; it cannot be disabled.
// RULE23: Parity is generated per written lane and checked per read lane.
`timescale 1ns/1ps
module omd_decode (
	input wire logic clk, // Board clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic cpu_start, // One-cycle pulse that opens an access.
	input wire logic [31:0] cpu_addr, // Byte address of the access.
	input wire logic cpu_write, // High for a write.
	input wire logic [3:0] cpu_be, // Byte lanes taking part.
	input wire logic cpu_burst, // Four-beat burst request.
	input wire logic [31:0] cpu_wdata, // Write data.
	output logic cpu_ack, // One-cycle pulse per finished beat.
	output logic [31:0] cpu_rdata, // Read data, valid with the ack.
	output logic cpu_port8, // The current access is to an 8-bit port.
	output logic par_irq, // Level 7 parity interrupt request.
	input wire logic par_irq_clr, // One-cycle clear of the request.
	input wire omd_pkg::omd_speed_t dram_speed, // Fitted DRAM speed grade.
	output logic dram_cs, // DRAM cycle in progress.
	output logic dram_we, // DRAM write.
	output logic [21:0] dram_addr, // DRAM longword address.
	output logic [3:0] dram_be, // DRAM byte lanes.
	output logic [31:0] dram_wdata, // DRAM write data.
	output logic [3:0] dram_wpar, // DRAM write parity.
	input wire logic [31:0] dram_rdata, // DRAM read data.
	input wire logic [3:0] dram_rpar, // DRAM read parity.
	input wire logic [21:0] rom0_mask, // Address bits decoded by the lower ROM.
	input wire logic [21:0] rom1_mask, // Address bits decoded by the upper ROM.
	output logic [1:0] rom_cs, // Socket selects, bit 1 for the upper socket.
	output logic rom_we, // Socket write strobe.
	output logic [21:0] rom_addr, // Socket byte address.
	output logic [7:0] rom_wdata, // Socket write byte.
	input wire logic [7:0] rom_rdata, // Socket read byte.
	input wire logic ee_rdy_in, // Ready line of a socket EEPROM.
	output logic cio_ee_rdy // Ready line towards the parallel I/O unit.
);
	import omd_pkg::*;

	typedef enum logic [1:0] {
		OMD_IDLE,
		OMD_DRAM,
		OMD_ROM,
		OMD_NV
	} omd_state_t;

	typedef struct packed {
		omd_state_t st;
		logic [4:0] cnt;
		logic [1:0] beat;
		logic burst;
		logic write;
		logic [3:0] be;
		logic [31:0] addr;
		logic ack;
		logic [31:0] rdata;
		logic port8;
		logic dram_cs;
		logic dram_we;
		logic [3:0] dram_be;
		logic [31:0] dram_wdata;
		logic [3:0] dram_wpar;
		logic [1:0] rom_cs;
		logic rom_we;
		logic [21:0] rom_addr;
		logic [7:0] rom_wdata;
		logic par_irq;
		logic ee_rdy;
		logic nv_req;
		logic nv_we;
		logic [7:0] nv_addr;
		logic [3:0] nv_wdata;
		logic nv_store;
		logic nv_recall;
	} omd_regs_t;

	omd_regs_t r;
	omd_regs_t next_r;
	omd_nv_if nv ();

	logic hit_dram;
	logic hit_rom;
	logic hit_nv;
	logic hit_ctl;
	logic par_bad;

	// Address decode of the incoming access.
	assign hit_dram = cpu_addr[31:24] == DRAM_TOP; // [RULE8]
	assign hit_rom = cpu_addr[31:23] == ROM_TOP; // [RULE21]
	assign hit_nv = cpu_addr[31:8] == NV_WIN_TOP; // [RULE14]
	assign hit_ctl = cpu_addr == NV_STORE || cpu_addr == NV_RECALL;

	// Parity mismatch on any lane that the read actually uses.
	assign par_bad = |((omd_lane_par(dram_rdata) ^ dram_rpar) & r.be); // [RULE23]

	// Next state of the whole decoder.
	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.nv_req = 1'b0;
		next_r.nv_store = 1'b0;
		next_r.nv_recall = 1'b0;
		next_r.ee_rdy = ee_rdy_in; // [RULE6]
		if (par_irq_clr) begin
			next_r.par_irq = 1'b0;
		end
		unique case (r.st)
			OMD_IDLE: begin
				if (cpu_start) begin
					next_r.addr = cpu_addr;
					next_r.write = cpu_write;
					next_r.be = cpu_be;
					next_r.burst = cpu_burst;
					next_r.beat = 2'h0;
					if (hit_dram) begin
						next_r.st = OMD_DRAM;
						next_r.port8 = 1'b0;
						next_r.dram_cs = 1'b1;
						next_r.dram_we = cpu_write;
						next_r.dram_be = cpu_be;
						next_r.dram_wdata = cpu_wdata;
						next_r.dram_wpar = omd_lane_par(cpu_wdata); // [RULE7] [RULE23]
						next_r.cnt = omd_first_wait(dram_speed, cpu_write); // [RULE11]
					end else if (hit_rom) begin
						// The whole socket sees the byte; masking repeats a small part. [RULE1] [RULE2]
						next_r.st = OMD_ROM;
						next_r.port8 = 1'b1;
						next_r.rom_cs = cpu_addr[ROM_BITS] ? 2'b10 : 2'b01; // [RULE21]
						next_r.rom_addr = cpu_addr[ROM_BITS-1:0] & (cpu_addr[ROM_BITS] ? rom1_mask : rom0_mask);
						next_r.rom_we = cpu_write; // [RULE3] [RULE4]
						next_r.rom_wdata = cpu_wdata[31:24];
						next_r.cnt = ROM_WAIT;
					end else if (hit_nv) begin
						next_r.st = OMD_NV;
						next_r.port8 = 1'b1;
						next_r.nv_req = 1'b1; // [RULE14]
						next_r.nv_we = cpu_write;
						next_r.nv_addr = cpu_addr[7:0];
						next_r.nv_wdata = cpu_wdata[27:24]; // [RULE13]
					end else if (hit_ctl) begin
						// Trigger cycles end at once; the copy runs in the background. [RULE18]
						next_r.st = OMD_NV;
						next_r.port8 = 1'b1;
						next_r.nv_store = cpu_write && cpu_addr == NV_STORE; // [RULE16]
						next_r.nv_recall = !cpu_write && cpu_addr == NV_RECALL; // [RULE15]
					end
				end
			end
			OMD_DRAM: begin
				if (r.cnt != 5'h0) begin
					next_r.cnt = r.cnt - 5'h1;
				end else begin
					// Reads past the fitted size end like any other read. [RULE9]
					next_r.ack = 1'b1;
					if (!r.write) begin
						next_r.rdata = dram_rdata;
					end
					if (r.burst && r.beat != LAST_BEAT) begin
						next_r.beat = r.beat + 2'h1;
						next_r.addr[3:2] = r.addr[3:2] + 2'h1;
						next_r.cnt = BURST_W; // [RULE11]
					end else begin
						next_r.st = OMD_IDLE;
						next_r.dram_cs = 1'b0;
						next_r.dram_we = 1'b0;
					end
				end
			end
			OMD_ROM: begin
				if (r.cnt != 5'h0) begin
					next_r.cnt = r.cnt - 5'h1;
				end else begin
					next_r.ack = 1'b1;
					next_r.rdata = {4{rom_rdata}}; // [RULE2]
					next_r.st = OMD_IDLE;
					next_r.rom_cs = 2'b00;
					next_r.rom_we = 1'b0;
				end
			end
			OMD_NV: begin
				next_r.ack = 1'b1;
				next_r.rdata = {4{4'h0, nv.rdata}}; // [RULE13]
				next_r.st = OMD_IDLE;
			end
		endcase
		// A parity error in the clear cycle still sets the request. [RULE22]
		if (r.st == OMD_DRAM && r.cnt == 5'h0 && !r.write && par_bad) begin
			next_r.par_irq = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Nibble memory link and the memory itself.
	// The request leaves with the start, so the memory's registered nibble is ready for the ack.
	assign nv.req = next_r.nv_req; // [RULE14]
	assign nv.we = next_r.nv_we;
	assign nv.addr = next_r.nv_addr;
	assign nv.wdata = next_r.nv_wdata;
	assign nv.store = next_r.nv_store; // [RULE16]
	assign nv.recall = next_r.nv_recall; // [RULE15]

	omd_nvram u_nvram (
		.clk(clk),
		.rst_n(rst_n),
		.nv(nv.mem)
	);

	// Outputs come straight from the state register.
	assign cpu_ack = r.ack;
	assign cpu_rdata = r.rdata;
	assign cpu_port8 = r.port8;
	assign par_irq = r.par_irq;
	assign dram_cs = r.dram_cs;
	assign dram_we = r.dram_we;
	assign dram_addr = r.addr[23:2];
	assign dram_be = r.dram_be;
	assign dram_wdata = r.dram_wdata;
	assign dram_wpar = r.dram_wpar;
	assign rom_cs = r.rom_cs;
	assign rom_we = r.rom_we;
	assign rom_addr = r.rom_addr;
	assign rom_wdata = r.rom_wdata;
	assign cio_ee_rdy = r.ee_rdy;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// First DRAM beat arrives after the exact wait count of the grade.
	dram_rd100_a: assert property (r.st == OMD_IDLE && cpu_start && hit_dram && !cpu_write // [RULE11]
		&& dram_speed == OMD_SPD_100 |=> !cpu_ack [*4] ##1 cpu_ack)
		else $error("100 ns read wait count wrong");
	dram_wr80_a: assert property (r.st == OMD_IDLE && cpu_start && hit_dram && cpu_write // [RULE11]
		&& dram_speed == OMD_SPD_80 |=> !cpu_ack [*3] ##1 cpu_ack)
		else $error("80 ns write wait count wrong");
	dram_rd60_a: assert property (r.st == OMD_IDLE && cpu_start && hit_dram && !cpu_write // [RULE11]
		&& dram_speed == OMD_SPD_60 |=> !cpu_ack [*3] ##1 cpu_ack)
		else $error("60 ns read wait count wrong");
	burst_beat_gap_a: assert property (cpu_ack && r.st == OMD_DRAM |=> !cpu_ack ##1 cpu_ack) // [RULE11]
		else $error("burst beat spacing wrong");
	parity_gen_a: assert property (dram_cs && dram_we |-> dram_wpar == omd_lane_par(dram_wdata)) // [RULE23]
		else $error("write parity wrong");
	parity_irq_a: assert property (r.st == OMD_DRAM && r.cnt == 5'h0 && !r.write && par_bad // [RULE22]
		|=> par_irq && cpu_ack)
		else $error("parity error not raised");
	rom_mirror_a: assert property (rom_cs == 2'b01 |-> (rom_addr & ~rom0_mask) == 22'h0 && cpu_port8) // [RULE1]
		else $error("lower ROM mirror wrong");
	rom_one_socket_a: assert property (rom_cs != 2'b00 |-> rom_cs != 2'b11 ##1 (rom_cs == 2'b00 || $stable(rom_cs))) // [RULE2]
		else $error("ROM lanes split");
	nv_no_stall_a: assert property (r.st == OMD_IDLE && cpu_start && (hit_nv || hit_ctl) // [RULE18]
		|-> ##2 cpu_ack)
		else $error("nibble access stalled");
	store_trig_a: assert property (r.st == OMD_IDLE && cpu_start && cpu_write && cpu_addr == NV_STORE // [RULE16]
		|-> nv.store && !nv.recall)
		else $error("store not started");
	recall_trig_a: assert property (r.st == OMD_IDLE && cpu_start && !cpu_write // [RULE15]
		&& cpu_addr == NV_RECALL |-> nv.recall && !nv.store)
		else $error("recall not started");
	ee_ready_a: assert property (##1 cio_ee_rdy == $past(ee_rdy_in)) // [RULE6]
		else $error("EEPROM ready not routed");

	burst_read_c: cover property (cpu_ack && r.st == OMD_DRAM && r.beat == LAST_BEAT);
	parity_err_c: cover property ($rose(par_irq));
	rom_write_c: cover property (rom_we && rom_cs == 2'b10);
	nv_store_c: cover property (nv.store);
endmodule : omd_decode

// ===== sim/omd_mem_model.sv
// Behavioural DRAM array and boot ROM sockets facing the decoder.
`timescale 1ns/1ps
module omd_mem_model (
	input wire logic clk, // Board clock.
	input wire logic dram_cs, // DRAM select.
	input wire logic dram_we, // DRAM write.
	input wire logic [21:0] dram_addr, // Longword address.
	input wire logic [3:0] dram_be, // Byte lanes.
	input wire logic [31:0] dram_wdata, // Write data.
	input wire logic [3:0] dram_wpar, // Write parity.
	output logic [31:0] dram_rdata, // Read data.
	output logic [3:0] dram_rpar, // Read parity.
	input wire logic [1:0] rom_cs, // Socket selects.
	input wire logic rom_we, // Socket write strobe.
	input wire logic [21:0] rom_addr, // Socket address.
	input wire logic [7:0] rom_wdata, // Socket write byte.
	output logic [7:0] rom_rdata, // Socket read byte.
	output logic [9:0] rom_seen // Select and byte of the last socket write.
);
	logic [35:0] mem [int];
	logic [35:0] w;
	logic tog = 1'b0;

	// Only written lanes take data and their parity bit, so byte writes leave the rest intact.
	always @(posedge clk) begin
		tog <= ~tog;
		if (dram_cs && dram_we) begin
			w = mem.exists(int'(dram_addr)) ? mem[int'(dram_addr)] : 36'h0;
			for (int i = 0; i < 4; i++) begin
				if (dram_be[i]) begin
					w[8*i +: 8] = dram_wdata[8*i +: 8];
					w[32+i] = dram_wpar[i];
				end
			end
			mem[int'(dram_addr)] = w;
		end
		if (rom_cs != 2'h0 && rom_we) begin
			rom_seen <= {rom_cs, rom_wdata};
		end
	end

	// Cells never written read zero with zero parity, which is bad odd parity.
	// Deselected lines show a pattern that changes every cycle, never the last value.
	always @* begin
		if (dram_cs && !dram_we) begin
			{dram_rpar, dram_rdata} = mem.exists(int'(dram_addr)) ? mem[int'(dram_addr)] : 36'h0;
		end else begin
			{dram_rpar, dram_rdata} = {36{tog}} ^ 36'h5_a5a5_a5a5;
		end
		rom_rdata = (rom_cs != 2'h0) ? ({rom_cs[1], rom_addr[6:0]} ^ 8'ha5) : {8{tog}};
	end
endmodule : omd_mem_model

// ===== sim/omd_decode_tb.sv
// Self-checking bench of the on-card memory decoder.
`timescale 1ns/1ps
module omd_decode_tb;
	import omd_pkg::*;
	logic clk, rst_n, cpu_start, cpu_write, cpu_burst, cpu_ack, cpu_port8, par_irq, par_irq_clr;
	logic dram_cs, dram_we, rom_we, ee_rdy_in, cio_ee_rdy, irq_at_ack;
	logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, dram_wdata, dram_rdata;
	logic [3:0] cpu_be, dram_be, dram_wpar, dram_rpar;
	logic [21:0] dram_addr, rom0_mask, rom1_mask, rom_addr;
	logic [1:0] rom_cs;
	logic [7:0] rom_wdata, rom_rdata;
	logic [9:0] rom_seen;
	omd_speed_t dram_speed;
	int err_total, checks, cyc;

	omd_decode omd_decode_i (.clk, .rst_n, .cpu_start, .cpu_addr, .cpu_write, .cpu_be, .cpu_burst, .cpu_wdata,
		.cpu_ack, .cpu_rdata, .cpu_port8, .par_irq, .par_irq_clr, .dram_speed, .dram_cs, .dram_we, .dram_addr,
		.dram_be, .dram_wdata, .dram_wpar, .dram_rdata, .dram_rpar, .rom0_mask, .rom1_mask, .rom_cs, .rom_we,
		.rom_addr, .rom_wdata, .rom_rdata, .ee_rdy_in, .cio_ee_rdy);
	omd_mem_model omd_mem_model_i (.clk, .dram_cs, .dram_we, .dram_addr, .dram_be, .dram_wdata, .dram_wpar,
		.dram_rdata, .dram_rpar, .rom_cs, .rom_we, .rom_addr, .rom_wdata, .rom_rdata, .rom_seen);

	// Free-running 100 MHz board clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cuts a hang short well beyond the roughly 1200 cycles the tests need.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			err_total++;
			$display("mismatch at %0t: run took too long", $time);
			end_sim();
		end
	end

	// Compares a value of the design.
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk32

	// Compares a cycle count seen by the bench.
	task automatic chk_n(input int got, input int exp, input string what);
		checks++;
		if (got != exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask : chk_n

	// One access of the given beats; the first ack is due lat cycles after start, later ones every 2.
	task automatic acc(input logic [31:0] a, input logic wr, input logic [3:0] be, input int beats,
			input logic [31:0] d, input int lat, input logic ck, input logic [31:0] exp);
		int n;
		@(posedge clk);
		#1;
		cpu_start = 1'b1;
		cpu_addr = a;
		cpu_write = wr;
		cpu_be = be;
		cpu_burst = (beats > 1);
		cpu_wdata = d;
		n = 0;
		for (int b = 0; b < beats; b++) begin
			do begin
				@(posedge clk);
				#1;
				cpu_start = 1'b0;
				n++;
			end while (cpu_ack !== 1'b1 && n < 60);
			chk_n(n, (b == 0) ? lat : 2, "ack cycle");
			irq_at_ack = par_irq;
			if (ck) begin
				chk32(cpu_rdata, exp, "read data");
			end
			n = 0;
		end
	endtask : acc

	// Socket decode, mirroring, byte port and write pass-through.
	task automatic t_rom();
		acc(32'h003f_0005, 1'b0, 4'h8, 1, 32'h0, 27, 1'b1, {4{8'ha0}});
		chk32(32'(cpu_port8), 32'h1, "byte port");
		acc(32'h0000_0005, 1'b0, 4'h8, 1, 32'h0, 27, 1'b1, {4{8'ha0}});
		acc(32'h0041_0003, 1'b0, 4'h8, 1, 32'h0, 27, 1'b1, {4{8'h26}});
		acc(32'h0000_0000, 1'b1, 4'h8, 1, 32'h0300_0000, 27, 1'b0, 32'h0);
		chk32(32'(rom_seen), {22'h0, 2'b01, 8'h03}, "page select");
		acc(32'h0040_0001, 1'b1, 4'h8, 1, 32'h5a00_0000, 27, 1'b0, 32'h0);
		chk32(32'(rom_seen), {22'h0, 2'b10, 8'h5a}, "eeprom write");
		$display("test rom done");
	endtask : t_rom

	// The EEPROM ready line reaches the parallel I/O one clock later.
	task automatic t_ee();
		@(posedge clk);
		#1 ee_rdy_in = 1'b1;
		chk32(32'(cio_ee_rdy), 32'h0, "ready early");
		@(posedge clk);
		#1 chk32(32'(cio_ee_rdy), 32'h1, "ready high");
		ee_rdy_in = 1'b0;
		@(posedge clk);
		#1 chk32(32'(cio_ee_rdy), 32'h0, "ready low");
		$display("test eeprom ready done");
	endtask : t_ee

	// Single accesses at each speed grade, with data and parity round trip.
	task automatic t_dram();
		int rdw[3] = '{3, 3, 2};
		int wrw[3] = '{3, 2, 2};
		for (int s = 0; s < 3; s++) begin
			dram_speed = omd_speed_t'(s);
			acc(32'h0300_0100 + 32'(s * 4), 1'b1, 4'hf, 1, 32'ha5c3_0f00 + 32'(s), wrw[s] + 2, 1'b0, 32'h0);
			acc(32'h0300_0100 + 32'(s * 4), 1'b0, 4'hf, 1, 32'h0, rdw[s] + 2, 1'b1, 32'ha5c3_0f00 + 32'(s));
			chk32(32'(irq_at_ack), 32'h0, "parity flag");
			chk32(32'(cpu_port8), 32'h0, "wide port");
		end
		dram_speed = OMD_SPD_60;
		acc(32'h0300_0200, 1'b1, 4'hf, 4, 32'h0f1e_2d3c, 4, 1'b0, 32'h0);
		acc(32'h0300_0200, 1'b0, 4'hf, 4, 32'h0, 4, 1'b1, 32'h0f1e_2d3c);
		$display("test dram timing done");
	endtask : t_dram

	// Sizing by byte writes, then a read past the fitted memory flags parity.
	task automatic t_size();
		dram_speed = OMD_SPD_100;
		for (int k = 0; k < 4; k++) begin
			acc(32'h0310_0000 + 32'(k), 1'b1, 4'h8 >> k, 1, 32'h1234_5678, 5, 1'b0, 32'h0);
		end
		acc(32'h0310_0000, 1'b0, 4'hf, 1, 32'h0, 5, 1'b1, 32'h1234_5678);
		chk32(32'(irq_at_ack), 32'h0, "parity after byte writes");
		acc(32'h0380_0000, 1'b0, 4'hf, 1, 32'h0, 5, 1'b0, 32'h0);
		chk32(32'(irq_at_ack), 32'h1, "parity error");
		repeat (3) @(posedge clk);
		#1 chk32(32'(par_irq), 32'h1, "request held");
		par_irq_clr = 1'b1;
		@(posedge clk);
		#1 par_irq_clr = 1'b0;
		@(posedge clk);
		#1 chk32(32'(par_irq), 32'h0, "request cleared");
		$display("test sizing and parity done");
	endtask : t_size

	// Nibble window, store by test-and-set, recall restores the stored value.
	task automatic t_nv();
		acc(32'h0270_0000, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		repeat (300) @(posedge clk);
		acc(32'h0250_0012, 1'b1, 4'h8, 1, 32'h0a00_0000, 2, 1'b0, 32'h0);
		acc(32'h0250_00ff, 1'b1, 4'h8, 1, 32'h0500_0000, 2, 1'b0, 32'h0);
		acc(32'h0250_00ff, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		chk32({28'h0, cpu_rdata[27:24]}, 32'h5, "nibble back to back");
		acc(32'h0250_0012, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		chk32({28'h0, cpu_rdata[27:24]}, 32'ha, "nibble low");
		acc(32'h0260_0000, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		acc(32'h0260_0000, 1'b1, 4'h8, 1, 32'h8000_0000, 2, 1'b0, 32'h0);
		repeat (300) @(posedge clk);
		acc(32'h0250_0012, 1'b1, 4'h8, 1, 32'h0300_0000, 2, 1'b0, 32'h0);
		acc(32'h0270_0000, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		repeat (300) @(posedge clk);
		acc(32'h0250_0012, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		chk32({28'h0, cpu_rdata[27:24]}, 32'ha, "recalled nibble");
		acc(32'h0250_00ff, 1'b0, 4'h8, 1, 32'h0, 2, 1'b0, 32'h0);
		chk32({28'h0, cpu_rdata[27:24]}, 32'h5, "second nibble");
		$display("test nonvolatile ram done");
	endtask : t_nv

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	// Reset for 8 cycles, then every scenario in turn.
	initial begin
		{rst_n, cpu_start, cpu_write, cpu_burst, par_irq_clr, ee_rdy_in} = 6'h0;
		{cpu_addr, cpu_wdata, cpu_be} = 68'h0;
		dram_speed = OMD_SPD_100;
		rom0_mask = 22'h00_ffff;
		rom1_mask = 22'h00_ffff;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		t_rom();
		t_ee();
		t_dram();
		t_size();
		t_nv();
		end_sim();
	end
endmodule : omd_decode_tb
